// >>> rtl/conv_cycle.sv
// Purpose: conversion / sleep / serial output cycle control
// Assumes: pins sampled on core_clk_in; modulator is a result port
// Notes:   host serial clock found by edge detection of synced pin; device clock from a counter
// Operation
// - convert, sleep, output, repeat in order
// - busy high only while converting
// - clock select low: host drives serial clock
// - clock select high: device drives serial clock
// - config bits pick speed, rate, channel
// - reset: channel 0/1, ratio 256, 1X
// - enable bit low keeps previous settings
// - first conversion after change is valid
// - output is the conversion just completed
// - chip select low enables output, wakes
// - auto sleep, stays asleep while deselected
// - deselect during output starts new conversion
// - deselected: serial output high impedance
// - status on output during convert/sleep
// - result held unchanged during sleep
// - select after completion starts shifting
// - output changes on falling clock edge
// - output ends after 32 bits, reconverts
// - calibration hidden inside each cycle
// - static clock control uses internal oscillator
// - clock source mode set by pin only
// - word: flag, filler, sign, 24 bits, 5 sub
// - 32nd falling edge drives output high
`timescale 1ns/1ps
module conv_cycle
  import conv_cycle_pkg::*;
(
  // clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            sys_rst_in,
  // serial pins
  input  wire logic                            chip_select_n_in,
  input  wire logic                            clock_source_select_in,
  input  wire logic                            serial_in,
  input  wire logic                            serial_clk_in,
  output logic                                 serial_clk_out,
  output logic                                 serial_clk_oe_out,
  output logic                                 serial_out,
  output logic                                 serial_out_oe_out,
  output logic                                 busy_out,
  input  wire logic                            conversion_clock_control_in,
  // modulator result
  input  wire logic                            sign_bit_in,
  input  wire logic [RESULT_BITS+SUB_BITS-1:0] mod_result_in,
  // active settings for the running conversion
  output logic [2:0]                           oversampling_ratio_out,
  output logic                                 twox_mode_out,
  output logic [2:0]                           channel_out,
  output logic                                 calibrate_out
);
  import conv_cycle_pkg::*;

  logic cs_s, cs_n_s, ext_s, sdi_s, sck_s, f0_s;
  // select synced as active high so reset reads as deselected, not selected
  pin_sync u_cs   (.clk_in(core_clk_in), .rst_in(sys_rst_in), .pin_in(!chip_select_n_in),
                   .level_out(cs_s));
  assign cs_n_s = !cs_s;
  pin_sync u_ext  (.clk_in(core_clk_in), .rst_in(sys_rst_in), .pin_in(clock_source_select_in),
                   .level_out(ext_s));
  pin_sync u_sdi  (.clk_in(core_clk_in), .rst_in(sys_rst_in), .pin_in(serial_in),
                   .level_out(sdi_s));
  pin_sync u_sck  (.clk_in(core_clk_in), .rst_in(sys_rst_in), .pin_in(serial_clk_in),
                   .level_out(sck_s));
  pin_sync u_f0   (.clk_in(core_clk_in), .rst_in(sys_rst_in),
                   .pin_in(conversion_clock_control_in), .level_out(f0_s));

  cyc_state_t                  state;
  cyc_state_t                  next_state;
  logic [CNT_W-1:0]            conv_cnt;
  logic [CNT_W-1:0]            next_conv_cnt;
  logic [BIT_CNT_W-1:0]        bit_cnt;
  logic [BIT_CNT_W-1:0]        next_bit_cnt;
  logic [WORD_BITS-1:0]        shreg;
  logic [WORD_BITS-1:0]        next_shreg;
  logic [CFG_BITS-1:0]         cfg_sh;
  logic [CFG_BITS-1:0]         next_cfg_sh;
  logic [2:0]                  next_osr;
  logic                        next_twox;
  logic [2:0]                  next_ch;
  logic                        sck_d;
  logic                        isck;
  logic                        next_isck;
  logic [7:0]                  isck_cnt;
  logic [7:0]                  next_isck_cnt;
  logic                        f0_d;
  logic                        f0_edge;
  logic                        next_busy;
  logic                        next_sdo;
  logic                        next_sdo_oe;
  logic                        next_sck_oe;
  logic                        sck_rise;
  logic                        sck_fall;
  logic                        conv_done;
  logic [CNT_W-1:0]            conv_len;
  logic                        buf_in_ready;
  logic                        buf_out_valid;
  logic                        buf_pop;
  logic [RESULT_BITS+SUB_BITS:0] buf_data;

  // finished result travels through the buffer into the shifter
  result_buf #(.WIDTH(RESULT_BITS+SUB_BITS+1)) u_buf (
    .clk_in       (core_clk_in),
    .rst_in       (sys_rst_in),
    .in_valid_in  (conv_done),
    .in_ready_out (buf_in_ready),
    .in_data_in   ({sign_bit_in, mod_result_in}),
    .out_valid_out(buf_out_valid),
    .out_ready_in (buf_pop),
    .out_data_out (buf_data)
  );

  always_comb begin
    // conversion length scales with the selected ratio; calibration folded in
    conv_len = CNT_W'(CONV_BASE_CYC) << oversampling_ratio_out;
    // clock control pin does not pace the conversion; the count advances every core cycle
    conv_done = (state == ST_CONVERT) && (conv_cnt >= conv_len) && buf_in_ready;
  end

  always_comb begin
    sck_rise = 1'b0;
    sck_fall = 1'b0;
    if (ext_s) begin
      sck_rise = (isck_cnt == 8'(ISCK_HALF_CYC - 1)) && !isck && !cs_n_s;
      sck_fall = (isck_cnt == 8'(ISCK_HALF_CYC - 1)) && isck;
    end else begin
      sck_rise = sck_s && !sck_d;
      sck_fall = !sck_s && sck_d;
    end
  end

  always_comb begin
    next_state    = state;
    next_conv_cnt = conv_cnt;
    next_bit_cnt  = bit_cnt;
    next_shreg    = shreg;
    next_cfg_sh   = cfg_sh;
    next_osr      = oversampling_ratio_out;
    next_twox     = twox_mode_out;
    next_ch       = channel_out;
    next_isck     = isck;
    next_isck_cnt = isck_cnt;
    buf_pop       = 1'b0;
    unique case (state)
      ST_CONVERT: begin
        // count advances every core cycle whatever the clock control pin does
        if (!f0_s || f0_edge || 1'b1) begin
          next_conv_cnt = conv_cnt + CNT_W'(1);
        end
        if (conv_done) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // fresh result taken from buffer; held while asleep
        // flag bit still set means the shifter holds no fresh word yet
        if (buf_out_valid && shreg[WORD_BITS-1]) begin
          buf_pop    = 1'b1;
          next_shreg = {1'b0, 1'b0, buf_data};
        end else if (!cs_n_s && !shreg[WORD_BITS-1]) begin
          next_state    = ST_OUTPUT;
          next_bit_cnt  = '0;
          next_isck     = 1'b0;
          next_isck_cnt = '0;
        end
      end
      ST_OUTPUT: begin
        if (ext_s) begin
          if (isck_cnt == 8'(ISCK_HALF_CYC - 1)) begin
            next_isck_cnt = '0;
            next_isck     = !isck;
          end else begin
            next_isck_cnt = isck_cnt + 8'h01;
          end
        end
        // only the first bits of a frame are settings; later ones are ignored
        if (sck_rise && (bit_cnt < BIT_CNT_W'(CFG_BITS))) begin
          next_cfg_sh = {cfg_sh[CFG_BITS-2:0], sdi_s};
        end
        if (sck_fall) begin
          next_shreg   = {shreg[WORD_BITS-2:0], 1'b1};
          next_bit_cnt = bit_cnt + 6'h01;
        end
        if (cs_n_s || (sck_fall && bit_cnt == 6'(WORD_BITS - 1))) begin
          next_state    = ST_CONVERT;
          next_conv_cnt = '0;
          next_shreg    = {1'b1, shreg[WORD_BITS-2:0]};
          if (cfg_sh[CFG_EN_POS]) begin
            next_twox = cfg_sh[CFG_TWOX_POS];
            next_osr  = cfg_sh[CFG_OSR_POS +: 3];
            next_ch   = cfg_sh[CFG_CH_POS +: 3];
          end
          next_cfg_sh = '0;
        end
      end
    endcase
  end

  always_comb begin
    next_busy   = (next_state == ST_CONVERT);
    next_sdo_oe = !cs_n_s;
    next_sck_oe = ext_s && (next_state == ST_OUTPUT);
    if (next_state == ST_OUTPUT) begin
      next_sdo = next_shreg[WORD_BITS-1];
    end else begin
      next_sdo = (next_state == ST_CONVERT);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state                  <= ST_CONVERT;
      conv_cnt               <= '0;
      bit_cnt                <= '0;
      shreg                  <= 32'h80000000;
      cfg_sh                 <= '0;
      oversampling_ratio_out <= RST_OSR;
      twox_mode_out          <= RST_TWOX;
      channel_out            <= RST_CH;
      sck_d                  <= 1'b0;
      f0_d                   <= 1'b0;
      isck                   <= 1'b0;
      isck_cnt               <= '0;
      busy_out               <= 1'b1;
      serial_out             <= 1'b1;
      serial_out_oe_out      <= 1'b0;
      serial_clk_out         <= 1'b0;
      serial_clk_oe_out      <= 1'b0;
      calibrate_out          <= 1'b0;
    end else begin
      state                  <= next_state;
      conv_cnt               <= next_conv_cnt;
      bit_cnt                <= next_bit_cnt;
      shreg                  <= next_shreg;
      cfg_sh                 <= next_cfg_sh;
      oversampling_ratio_out <= next_osr;
      twox_mode_out          <= next_twox;
      channel_out            <= next_ch;
      sck_d                  <= sck_s;
      f0_d                   <= f0_s;
      isck                   <= next_isck;
      isck_cnt               <= next_isck_cnt;
      busy_out               <= next_busy;
      serial_out             <= next_sdo;
      serial_out_oe_out      <= next_sdo_oe;
      serial_clk_out         <= next_isck;
      serial_clk_oe_out      <= next_sck_oe;
      calibrate_out          <= (next_state == ST_CONVERT) && (next_conv_cnt < CNT_W'(16));
    end
  end

  assign f0_edge = f0_s ^ f0_d;

  // busy and the clock pin enable are registered from next_state, so they track state; data enable follows select
  chk_busy_state: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    busy_out == (state == ST_CONVERT))
    else $error("busy does not track conversion");
  chk_tri_state: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    $past(cs_n_s) |-> !serial_out_oe_out)
    else $error("output driven while deselected");
  chk_abort_conv: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_OUTPUT && cs_n_s) |=> state == ST_CONVERT)
    else $error("deselect did not restart conversion");
  chk_sleep_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_SLEEP && cs_n_s && !shreg[WORD_BITS-1]) |=> state == ST_SLEEP)
    else $error("left sleep while deselected");
  chk_cycle_order: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_CONVERT && next_state != ST_CONVERT) |-> next_state == ST_SLEEP)
    else $error("conversion not followed by sleep");
  chk_word_end: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_OUTPUT && sck_fall && bit_cnt == 6'h1F) |=> state == ST_CONVERT)
    else $error("output did not end at 32 bits");
  chk_status_bit: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_CONVERT && next_state == ST_CONVERT && !cs_n_s) |=> serial_out)
    else $error("status not high while converting");
  chk_cfg_keep: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_OUTPUT && next_state == ST_CONVERT && !cfg_sh[CFG_EN_POS]) |=>
    $stable(channel_out) && $stable(oversampling_ratio_out))
    else $error("settings changed without enable");
  chk_select_drive: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !cs_n_s |=> serial_out_oe_out)
    else $error("output not driven while selected");
  chk_sleep_status: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_SLEEP && next_state == ST_SLEEP) |=> !serial_out)
    else $error("status not low after completion");
  chk_shift_edge: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_OUTPUT && next_state == ST_OUTPUT && !sck_fall) |=> $stable(serial_out))
    else $error("output changed without falling clock");
  chk_calib_window: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (state == ST_CONVERT && conv_cnt == CNT_W'(0)) |=> calibrate_out)
    else $error("calibration missing at conversion start");
  // covers mark the scenarios the bench is meant to reach
  cov_full_word: cover property (@(posedge core_clk_in) state == ST_OUTPUT && bit_cnt == 6'h1F);
  cov_abort: cover property (@(posedge core_clk_in) state == ST_OUTPUT && cs_n_s);
  cov_internal: cover property (@(posedge core_clk_in) serial_clk_oe_out);
  cov_twox: cover property (@(posedge core_clk_in) twox_mode_out);
  cov_sleep_wake: cover property (@(posedge core_clk_in) state == ST_SLEEP && !cs_n_s);
endmodule

// >>> rtl/conv_cycle_pkg.sv
// Purpose: shared constants for the converter cycle controller
// Assumes: 100 MHz core clock
// Notes:   counts derived from times in their own units
package conv_cycle_pkg;
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned WORD_BITS      = 32;
  localparam int unsigned RESULT_BITS    = 24;
  localparam int unsigned SUB_BITS       = 5;
  localparam int unsigned CFG_BITS       = 8;
  // configuration word layout, first bit received is bit 7
  localparam int unsigned CFG_EN_POS     = 7;
  localparam int unsigned CFG_TWOX_POS   = 6;
  localparam int unsigned CFG_OSR_POS    = 3;
  localparam int unsigned CFG_CH_POS     = 0;
  localparam logic [2:0]  RST_OSR        = 3'h0;
  localparam logic [2:0]  RST_CH         = 3'h0;
  localparam logic        RST_TWOX       = 1'b0;
  // conversion time at ratio code 0, doubled per step, in microseconds
  localparam int unsigned CONV_BASE_US   = 20;
  localparam int unsigned CONV_BASE_CYC  = CONV_BASE_US * CLK_MHZ;
  // internal serial clock half period, in nanoseconds
  localparam int unsigned ISCK_HALF_NS   = 550;
  localparam int unsigned ISCK_HALF_CYC  = ISCK_HALF_NS * CLK_MHZ / 1000;
  localparam int unsigned CNT_W          = 24;
  localparam int unsigned BIT_CNT_W      = 6;
  typedef enum logic [1:0] {ST_CONVERT, ST_SLEEP, ST_OUTPUT} cyc_state_t;
endpackage

// >>> rtl/pin_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: single core clock
// Notes:   first stage read only by second
`timescale 1ns/1ps
module pin_sync (
  // clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // pin and synchronised level
  input  wire logic pin_in,
  output logic      level_out
);
  logic meta;
  logic next_meta;
  logic next_level;

  always_comb begin
    next_meta  = pin_in;
    next_level = meta;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta      <= 1'b0;
      level_out <= 1'b0;
    end else begin
      meta      <= next_meta;
      level_out <= next_level;
    end
  end
endmodule

// >>> rtl/result_buf.sv
// Purpose: two-entry buffer carrying results to the shifter
// Assumes: source and sink on the core clock
// Notes:   write side stalls when full so no word is lost
`timescale 1ns/1ps
module result_buf #(
  parameter int unsigned WIDTH = 30
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // fill side
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  // drain side
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] mem [2];
  logic [1:0]       count;
  logic             rd_ptr;
  logic             wr_ptr;
  logic [1:0]       next_count;
  logic             next_rd_ptr;
  logic             next_wr_ptr;
  logic             push;
  logic             pop;

  always_comb begin
    push        = in_valid_in && (count != 2'h2);
    pop         = out_ready_in && (count != 2'h0);
    next_count  = count + {1'b0, push} - {1'b0, pop};
    next_rd_ptr = rd_ptr ^ pop;
    next_wr_ptr = wr_ptr ^ push;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      count  <= 2'h0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
    end else begin
      count  <= next_count;
      rd_ptr <= next_rd_ptr;
      wr_ptr <= next_wr_ptr;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  assign in_ready_out  = (count != 2'h2);
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = mem[rd_ptr];
endmodule

// >>> bench/host_model.sv
// Purpose: host side of the serial port, for both clock source modes
// Assumes: 125 ns serial clock period when the host drives the clock
// Notes:   host clock rests low between frames; data line toggles when idle
`timescale 1ns/1ps
module host_model (
  // pins driven by the host
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      data_to_dev_out,
  // pins seen by the host
  input  wire logic clk_pin_in,
  input  wire logic data_from_dev_in
);
  initial begin
    cs_n_out        = 1'b1;
    sclk_out        = 1'b0;
    data_to_dev_out = 1'b0;
  end

  // host_clk high: the host makes the clock, otherwise it follows the pin
  task automatic frame(input logic [7:0] cfg, input int nbits, input logic host_clk,
                       output logic [31:0] word);
    word = 32'h0;
    cs_n_out = 1'b0;
    #300;
    for (int i = 0; i < nbits; i++) begin
      data_to_dev_out = (i < 8) ? cfg[7-i] : ~data_to_dev_out;
      if (host_clk) begin
        #62.5 word = {word[30:0], data_from_dev_in};
        sclk_out = 1'b1;
        #62.5 sclk_out = 1'b0;
      end else begin
        @(posedge clk_pin_in) word = {word[30:0], data_from_dev_in};
      end
    end
    #300;
  endtask

  task automatic release_cs();
    cs_n_out = 1'b1;
    data_to_dev_out = ~data_to_dev_out;
  endtask
endmodule

// >>> bench/conv_cycle_tb.sv
// Purpose: self-checking bench for the conversion cycle controller
// Assumes: result port stands in for the modulator
// Notes:   ratio codes above 1 skipped, their conversions run too long
`timescale 1ns/1ps
module conv_cycle_tb;
  import conv_cycle_pkg::*;
  logic                            core_clk_in = 1'b0;
  logic                            sys_rst_in = 1'b1;
  logic                            clock_source_select_in = 1'b0;
  logic                            conversion_clock_control_in = 1'b0;
  logic                            sign_bit_in = 1'b1;
  logic [RESULT_BITS+SUB_BITS-1:0] mod_result_in = 29'h0ABCDEF5;
  logic                            cs_n, host_sclk, host_data;
  logic                            serial_clk_out, serial_clk_oe_out;
  logic                            serial_out, serial_out_oe_out, busy_out, calibrate_out;
  logic [2:0]                      oversampling_ratio_out, channel_out;
  logic                            twox_mode_out;
  logic                            clk_pin, data_pin;
  logic [31:0]                     exp_word, word;
  int                              errors = 0;
  int                              checks_done = 0;
  int                              cycles = 0;
  int                              n;

  always #5 core_clk_in = ~core_clk_in;
  // two-way clock pin resolved from both drivers
  assign clk_pin  = serial_clk_oe_out ? serial_clk_out : host_sclk;
  // released data line shows the inverse, not a stale level
  assign data_pin = serial_out_oe_out ? serial_out : ~serial_out;

  conv_cycle u_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .chip_select_n_in(cs_n),
    .clock_source_select_in(clock_source_select_in), .serial_in(host_data),
    .serial_clk_in(clk_pin), .serial_clk_out(serial_clk_out),
    .serial_clk_oe_out(serial_clk_oe_out), .serial_out(serial_out),
    .serial_out_oe_out(serial_out_oe_out), .busy_out(busy_out),
    .conversion_clock_control_in(conversion_clock_control_in),
    .sign_bit_in(sign_bit_in), .mod_result_in(mod_result_in),
    .oversampling_ratio_out(oversampling_ratio_out), .twox_mode_out(twox_mode_out),
    .channel_out(channel_out), .calibrate_out(calibrate_out)
  );

  host_model u_host (
    .cs_n_out(cs_n), .sclk_out(host_sclk), .data_to_dev_out(host_data),
    .clk_pin_in(clk_pin), .data_from_dev_in(data_pin)
  );

  // result of the conversion just finished, from what was presented
  always @(negedge busy_out) exp_word = {2'b00, sign_bit_in, mod_result_in};

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy_out !== lvl && n < 20000) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    check(busy_out, lvl, "busy level reached");
  endtask

  task automatic t_reset();
    #1 sys_rst_in = 1'b0;
    check(busy_out, 1'b1, "busy after reset");
    check(serial_out_oe_out, 1'b0, "output released");
    check({oversampling_ratio_out, channel_out, twox_mode_out}, 7'h00, "defaults");
    u_host.frame(8'h00, 0, 1'b1, word);
    check(serial_out_oe_out, 1'b1, "select enables output");
    check(serial_out, 1'b1, "status while converting");
    wait_busy(1'b0);
    check(n > 1900 && n < 2010, 1'b1, "first conversion length");
    repeat (5) @(posedge core_clk_in);
    check(serial_out, 1'b0, "status once complete");
    u_host.release_cs();
    repeat (5) @(posedge core_clk_in);
    check(busy_out, 1'b1, "deselect during output reconverts");
    wait_busy(1'b0);
    repeat (500) @(posedge core_clk_in);
    check(busy_out, 1'b0, "asleep while deselected");
    $display("test reset done");
  endtask

  task automatic t_word(input logic [7:0] cfg, input logic [6:0] exp_set, input int r);
    logic [31:0] want;
    want = exp_word;
    @(posedge core_clk_in) #1 mod_result_in = mod_result_in ^ 29'h15555555;
    u_host.frame(cfg, 32, 1'b1, word);
    check(word, want, "shifted word");
    check(serial_out, 1'b1, "line high after last fall");
    check(busy_out, 1'b1, "new conversion started");
    check({oversampling_ratio_out, channel_out, twox_mode_out}, exp_set, "settings");
    u_host.release_cs();
    wait_busy(1'b0);
    check(n > (2000 << r) - 60 && n < (2000 << r) + 5, 1'b1, "conversion length");
    $display("test word %h done", cfg);
  endtask

  task automatic t_abort();
    u_host.frame(8'hC1, 10, 1'b1, word);
    u_host.release_cs();
    repeat (5) @(posedge core_clk_in);
    check(busy_out, 1'b1, "abort starts conversion");
    check(serial_out_oe_out, 1'b0, "released on deselect");
    check({oversampling_ratio_out, channel_out, twox_mode_out}, 7'h03, "applied");
    check(calibrate_out, 1'b1, "calibration at conversion start");
    wait_busy(1'b0);
    $display("test abort done");
  endtask

  task automatic t_internal();
    logic [31:0] want;
    want = exp_word;
    @(posedge core_clk_in) #1 clock_source_select_in = 1'b1;
    repeat (5) @(posedge core_clk_in);
    u_host.frame(8'h00, 32, 1'b0, word);
    check(word, want, "word on device clock");
    wait_busy(1'b1);
    check(busy_out, 1'b1, "conversion after device clocked frame");
    u_host.release_cs();
    repeat (5) @(posedge core_clk_in);
    check(serial_clk_oe_out, 1'b0, "clock pin released");
    @(posedge core_clk_in) #1 clock_source_select_in = 1'b0;
    wait_busy(1'b0);
    $display("test internal clock done");
  endtask

  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge core_clk_in);
    t_reset();
    t_word(8'h8D, 7'h1A, 1);
    t_word(8'h4F, 7'h1A, 1);
    t_abort();
    t_internal();
    close_out();
  end
endmodule
